/* fan_commutator.sv */
// bridge drive, commutation, soft start and protection
`timescale 1ns/1ps
`include "fan_map.svh"
module fan_commutator
   import fan_pkg::*;
#(
   parameter int unsigned LOCK_ON_CYC  = `LOCK_ON_MS * (`CLK_HZ / 1000),
   parameter int unsigned LOCK_OFF_CYC = `LOCK_OFF_MS * (`CLK_HZ / 1000),
   parameter int unsigned SS_STEP_CYC  =
      `SS_MS * (`CLK_HZ / 1000) / `SS_LEVELS
)(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       speed_cmd,
   input  wire logic       hall_input,
   input  wire logic [1:0] min_speed_level,
   input  wire logic [7:0] ext_min_duty,
   input  wire logic       restart_current_cap,
   input  wire logic       overcurrent,
   input  wire logic       current_zero,
   output logic            bridge_out_a,
   output logic            bridge_out_a_oe_n,
   output logic            bridge_out_b,
   output logic            bridge_out_b_oe_n,
   output logic            min_speed_active,
   output logic            shutdown_active,
   output logic            lock_active,
   output logic [7:0]      duty_at_second_edge
);
   localparam logic [28:0] T_ON   = 29'(LOCK_ON_CYC - 1);
   localparam logic [28:0] T_OFF  = 29'(LOCK_OFF_CYC - 1);
   localparam logic [19:0] SS_LST = 20'(SS_STEP_CYC - 1);
   localparam logic [11:0] P_LAST = 12'(`PWM_PERIOD - 1);
   localparam logic [7:0]  B_LAST = 8'(`OC_BLANK_CYC - 1);
   localparam logic [4:0]  R_LAST = 5'(`RAMP_STEPS - 1);

   fan_t        st_r;
   fan_t        st_nxt;
   logic [7:0]  cmd_duty;
   logic [7:0]  min_lvl;
   logic [7:0]  target;
   logic [7:0]  eff;
   logic [7:0]  ph_duty;
   logic [12:0] ramp_p;
   logic [19:0] cmp_p;
   logic        pwm_on;
   logic        below;
   logic        shut;
   logic        edge_seen;
   logic        oc_trip;
   logic        lock_trip;
   logic        drive;
   logic        gap;
   logic [25:0] omax;
   logic [25:0] adj;
   logic [26:0] osum;
   logic [29:0] lead;

   // ****************************************
   // restart into soft start
   // ****************************************
   function automatic fan_t restart(input fan_t f);
      fan_t g;
      g = f;
      g.mode = M_START;
      g.ph = P_DRIVE;
      g.timer = 29'h0;
      g.ss_duty = 8'h00;
      g.ss_cnt = 20'h0;
      g.edges = 3'h0;
      g.frozen = 1'b0;
      g.per = 26'h0;
      g.elapsed = 26'h0;
      g.off_len = 26'h0;
      g.idx = 5'h00;
      g.zc_seen = 1'b0;
      g.lock_act = 1'b0;
      return g;
   endfunction : restart

   duty_meter u_meter (
      .clk     (clk),
      .sys_rst (sys_rst),
      .cmd     (st_r.cmd2),
      .duty    (cmd_duty)
   );

   // ****************************************
   // duty selection and pwm
   // ****************************************
   always_comb begin
      min_lvl = (st_r.ms2 == MS_MID) ? st_r.ext2 : `DUTY_MIN;
      below = cmd_duty < min_lvl;
      shut = (st_r.ms2 == MS_LOW) && (cmd_duty < `DUTY_MIN);
      target = below ? min_lvl : cmd_duty;
      eff = (st_r.mode == M_START) ? st_r.ss_duty : target;
      ramp_p = 13'h0000;
      case (st_r.ph)
         P_SON: begin
            ramp_p = 13'(eff) * 13'(st_r.idx);
            ph_duty = 8'(ramp_p >> 4);
         end
         P_SOFF: begin
            ramp_p = 13'(eff) * 13'(5'(`RAMP_STEPS) - st_r.idx);
            ph_duty = 8'(ramp_p >> 4);
         end
         P_DRIVE: ph_duty = eff;
         default: ph_duty = 8'h00;
      endcase
      cmp_p = 20'(ph_duty) * 20'(`PWM_PERIOD);
      pwm_on = st_r.pwm_cnt < 12'(cmp_p >> 8);
   end

   // ****************************************
   // state update
   // ****************************************
   always_comb begin
      st_nxt = st_r;
      st_nxt.hall1 = hall_input;
      st_nxt.hall2 = st_r.hall1;
      st_nxt.hall_q = st_r.hall2;
      st_nxt.cmd1 = speed_cmd;
      st_nxt.cmd2 = st_r.cmd1;
      st_nxt.oc1 = overcurrent;
      st_nxt.oc2 = st_r.oc1;
      st_nxt.lim1 = restart_current_cap;
      st_nxt.lim2 = st_r.lim1;
      st_nxt.zc1 = current_zero;
      st_nxt.zc2 = st_r.zc1;
      st_nxt.ms1 = min_speed_level;
      st_nxt.ms2 = min_speed_level_t'(st_r.ms1);
      st_nxt.ext1 = ext_min_duty;
      st_nxt.ext2 = st_r.ext1;
      st_nxt.pwm_cnt = (st_r.pwm_cnt == P_LAST) ? 12'h000 :
                       st_r.pwm_cnt + 12'h001;
      if (!st_r.oc2)
         st_nxt.blank = 8'h00;
      else if (st_r.blank != B_LAST)
         st_nxt.blank = st_r.blank + 8'h01;
      oc_trip = st_r.oc2 && (st_r.blank == B_LAST);
      edge_seen = st_r.hall2 != st_r.hall_q;
      lock_trip = !edge_seen && (st_r.timer == T_ON);
      omax = 26'((34'(st_r.elapsed) * 34'(`SOFF_DEG)) / 34'(`HALF_DEG));
      adj = st_r.elapsed >> `OFF_ADJ_SHIFT;
      osum = 27'(st_r.off_len) + 27'(adj);
      lead = 30'(st_r.off_len) + 30'({st_r.soff_step, 4'h0});
      case (st_r.mode)
         M_HALT: begin
            if (st_r.timer == T_OFF)
               st_nxt = restart(st_nxt);
            else
               st_nxt.timer = st_r.timer + 29'h1;
         end
         M_START, M_RUN: begin
            if (oc_trip || lock_trip) begin
               st_nxt.mode = M_HALT;
               st_nxt.timer = 29'h0;
               st_nxt.lock_act = lock_trip;
            end else if (shut) begin
               st_nxt = restart(st_nxt);
            end else if (edge_seen) begin
               st_nxt.timer = 29'h0;
               st_nxt.per = st_r.elapsed;
               st_nxt.elapsed = 26'h0;
               st_nxt.son_step = 26'((34'(st_r.elapsed) * 34'(`SON_DEG))
                  / 34'(`HALF_DEG * `RAMP_STEPS));
               st_nxt.soff_step = 26'((34'(st_r.elapsed) * 34'(`SOFF_DEG))
                  / 34'(`HALF_DEG * `RAMP_STEPS));
               st_nxt.ph = P_SON;
               st_nxt.idx = 5'h00;
               st_nxt.step_cnt = 26'h0;
               st_nxt.zc_seen = 1'b0;
               if (st_r.hall_q && !st_r.hall2) begin
                  if (st_r.zc_seen)
                     st_nxt.off_len = (st_r.off_len > adj) ?
                                      st_r.off_len - adj : 26'h0;
                  else
                     st_nxt.off_len = (osum > 27'(omax)) ?
                                      omax : 26'(osum);
               end
               if (st_r.edges != 3'(`START_EDGES))
                  st_nxt.edges = st_r.edges + 3'h1;
               if (st_r.edges == 3'h1)
                  st_nxt.duty2 = st_r.ss_duty;
            end else begin
               st_nxt.timer = st_r.timer + 29'h1;
               if (st_r.elapsed != `ELAPSED_MAX)
                  st_nxt.elapsed = st_r.elapsed + 26'h1;
               st_nxt.zc_seen = st_r.zc_seen || st_r.zc2;
               case (st_r.ph)
                  P_SON, P_SOFF: begin
                     if (st_r.step_cnt >= st_r.son_step &&
                         st_r.ph == P_SON ||
                         st_r.step_cnt >= st_r.soff_step &&
                         st_r.ph == P_SOFF) begin
                        st_nxt.step_cnt = 26'h0;
                        st_nxt.idx = st_r.idx + 5'h01;
                        if (st_r.idx == R_LAST) begin
                           st_nxt.idx = 5'h00;
                           st_nxt.ph = (st_r.ph == P_SON) ? P_DRIVE : P_GAP;
                        end
                     end else begin
                        st_nxt.step_cnt = st_r.step_cnt + 26'h1;
                     end
                  end
                  P_DRIVE: begin
                     if (st_r.per != 26'h0 &&
                         30'(st_r.elapsed) + lead >= 30'(st_r.per)) begin
                        st_nxt.ph = P_SOFF;
                        st_nxt.idx = 5'h00;
                        st_nxt.step_cnt = 26'h0;
                     end
                  end
                  P_GAP: st_nxt.ph = P_GAP;
                  default: st_nxt.ph = P_DRIVE;
               endcase
            end
            if (st_r.mode == M_START && !oc_trip && !lock_trip && !shut) begin
               if (st_r.lim2)
                  st_nxt.frozen = 1'b1;
               if (st_r.edges == 3'(`START_EDGES)) begin
                  st_nxt.mode = M_RUN;
               end else if (!st_r.frozen && !st_r.lim2) begin
                  if (st_r.ss_cnt == SS_LST) begin
                     st_nxt.ss_cnt = 20'h0;
                     if (st_r.ss_duty != `DUTY_FULL)
                        st_nxt.ss_duty = st_r.ss_duty + 8'h01;
                  end else begin
                     st_nxt.ss_cnt = st_r.ss_cnt + 20'h1;
                  end
               end
            end
         end
         default: st_nxt.mode = M_HALT;
      endcase
      drive = (st_r.mode != M_HALT) && !shut;
      gap = st_r.ph == P_GAP;
      st_nxt.out_a = drive && st_r.hall2 && pwm_on && !gap;
      st_nxt.oe_a_n = drive && st_r.hall2 && gap;
      st_nxt.out_b = drive && !st_r.hall2 && pwm_on && !gap;
      st_nxt.oe_b_n = drive && !st_r.hall2 && gap;
      st_nxt.min_act = !shut && below;
      st_nxt.shut_act = shut;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0;
         st_r.mode <= M_START;
         st_r.ph <= P_DRIVE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign bridge_out_a = st_r.out_a;
   assign bridge_out_a_oe_n = st_r.oe_a_n;
   assign bridge_out_b = st_r.out_b;
   assign bridge_out_b_oe_n = st_r.oe_b_n;
   assign min_speed_active = st_r.min_act;
   assign shutdown_active = st_r.shut_act;
   assign lock_active = st_r.lock_act;
   assign duty_at_second_edge = st_r.duty2;

   // ****************************************
   // checks
   // ****************************************
   default clocking dc @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_halt;
      st_r.mode == M_HALT;
   endsequence
   sequence s_leave;
      s_halt ##1 st_r.mode == M_START;
   endsequence
   sequence s_turn;
      edge_seen && drive && !oc_trip && !lock_trip;
   endsequence

   a_pwm_wrap: assert property (
      st_r.pwm_cnt == P_LAST |=> st_r.pwm_cnt == 12'h000)
      else $error("pwm period not kept");
   a_turn_son: assert property (
      s_turn |=> st_r.ph == P_SON && st_r.idx == 5'h00)
      else $error("hall change did not start soft-on");
   a_halt_low: assert property (
      s_halt |=> !bridge_out_a && !bridge_out_b &&
                 !bridge_out_a_oe_n && !bridge_out_b_oe_n)
      else $error("outputs not low while halted");
   a_son_other: assert property (
      st_r.ph == P_SON && st_r.hall2 |=> !bridge_out_b)
      else $error("second output switched in soft-on");
   a_gap_float: assert property (
      gap && drive && st_r.hall2 |=> bridge_out_a_oe_n && !bridge_out_b)
      else $error("gap output not floating");
   a_off_bound: assert property (
      edge_seen && st_r.mode != M_HALT |=> st_r.off_len <=
         26'((34'($past(st_r.elapsed)) * 34'(`SOFF_DEG)) / 34'(`HALF_DEG))
         || $past(shut) || $past(oc_trip) || $past(lock_trip))
      else $error("off gap beyond limit");
   a_restart_zero: assert property (
      s_leave |-> st_r.ss_duty == 8'h00 && st_r.edges == 3'h0)
      else $error("restart not from zero duty");
   a_start_end: assert property (
      st_r.mode == M_START && st_r.edges == 3'(`START_EDGES) &&
      !shut && !oc_trip && !lock_trip |=> st_r.mode == M_RUN)
      else $error("soft start did not end");
   a_freeze_hold: assert property (
      st_r.mode == M_START && st_r.frozen |=>
         $stable(st_r.ss_duty) || st_r.mode != M_START)
      else $error("frozen duty moved");
   a_floor_flag: assert property (
      st_r.ms2 != MS_LOW && below |=> min_speed_active)
      else $error("minimum speed mode missed");
   a_shut_off: assert property (
      shut |=> shutdown_active && !bridge_out_a && !bridge_out_b)
      else $error("shutdown not applied");
   a_lock_trip: assert property (
      lock_trip && st_r.mode != M_HALT |=> s_halt ##0 lock_active)
      else $error("lock not declared");
   a_oc_halt: assert property (
      oc_trip && st_r.mode != M_HALT |=> s_halt ##1 s_halt)
      else $error("overcurrent did not halt");
endmodule : fan_commutator

/* fan_map.svh */
// constants and behaviour notes for the fan commutator
// Notes on behaviour
// - bridge switches at fixed 26 kHz
// - output duty follows measured command duty linearly
// - hall level change swaps conducting bridge half
// - lock drives both outputs low for 3.6 s
// - soft-on ramps duty up in 16 steps
// - soft-off ramps duty down in 16 steps
// - off gap: active output floats, other low
// - off gap adapts to drive current zero crossing
// - soft start begins at zero duty
// - four hall changes end soft start ramp
// - start current trip freezes duty until four changes
// - high or floating level: internal 10% floor
// - low level: command under 10% shuts down
// - no hall change for 0.6 s locks
// - middle level: external minimum duty floor
// - blanked overcurrent halts bridge for 3.6 s
`ifndef FAN_MAP_SVH
`define FAN_MAP_SVH
`define CLK_HZ         100000000
`define FOUT_HZ        26000
`define PWM_PERIOD     (`CLK_HZ / `FOUT_HZ)
`define LOCK_ON_MS     600
`define LOCK_OFF_MS    3600
`define SS_MS          1400
`define SS_LEVELS      256
`define OC_BLANK_NS    1500
`define OC_BLANK_CYC   (`OC_BLANK_NS * (`CLK_HZ / 1000000) / 1000)
`define DUTY_MIN       8'h1A
`define DUTY_FULL      8'hFF
`define SON_DEG        24
`define SOFF_DEG       45
`define HALF_DEG       180
`define RAMP_STEPS     16
`define START_EDGES    4
`define OFF_ADJ_SHIFT  6
`define ELAPSED_MAX    26'h3FFFFFF
`define METER_MAX      14'h3FFF
`endif

/* fan_pkg.sv */
// types for the fan commutator
package fan_pkg;
   typedef enum logic [2:0] {
      M_START = 3'h1,
      M_RUN   = 3'h2,
      M_HALT  = 3'h4
   } mode_t;
   typedef enum logic [3:0] {
      P_SON   = 4'h1,
      P_DRIVE = 4'h2,
      P_SOFF  = 4'h4,
      P_GAP   = 4'h8
   } phase_t;
   typedef enum logic [1:0] {
      MS_LOW  = 2'h0,
      MS_MID  = 2'h1,
      MS_HIGH = 2'h2,
      MS_OPEN = 2'h3
   } min_speed_level_t;
   typedef struct packed {
      logic        cmd_q;
      logic [13:0] hi;
      logic [13:0] tot;
      logic [13:0] den;
      logic [14:0] rem;
      logic [3:0]  bits;
      logic [7:0]  quo;
      logic [7:0]  duty;
      logic        busy;
   } meter_t;
   typedef struct packed {
      logic hall1, hall2, hall_q, cmd1, cmd2;
      logic oc1, oc2, lim1, lim2, zc1, zc2;
      logic [1:0]  ms1;
      min_speed_level_t      ms2;
      logic [7:0]  ext1, ext2;
      mode_t       mode;
      phase_t      ph;
      logic [11:0] pwm_cnt;
      logic [25:0] elapsed, per, off_len;
      logic [25:0] son_step, soff_step, step_cnt;
      logic [4:0]  idx;
      logic [28:0] timer;
      logic [7:0]  blank;
      logic [2:0]  edges;
      logic [7:0]  ss_duty, duty2;
      logic [19:0] ss_cnt;
      logic frozen, zc_seen;
      logic out_a, oe_a_n, out_b, oe_b_n;
      logic min_act, shut_act, lock_act;
   } fan_t;
endpackage : fan_pkg

/* duty_meter.sv */
// duty measurement of the synchronised speed command
`timescale 1ns/1ps
`include "fan_map.svh"
module duty_meter
   import fan_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       cmd,
   output logic [7:0]      duty
);
   meter_t      mt_r;
   meter_t      mt_nxt;
   logic        rise;
   logic        stuck;
   logic [14:0] rem2;

   // ****************************************
   // period counting and restoring division
   // ****************************************
   always_comb begin
      mt_nxt = mt_r;
      mt_nxt.cmd_q = cmd;
      rise = cmd && !mt_r.cmd_q;
      stuck = mt_r.tot == `METER_MAX;
      rem2 = {mt_r.rem[13:0], 1'b0};
      if (rise || stuck) begin
         if (rise && !stuck && !mt_r.busy) begin
            mt_nxt.rem = {1'b0, mt_r.hi};
            mt_nxt.den = mt_r.tot;
            mt_nxt.bits = 4'h8;
            mt_nxt.quo = 8'h00;
            mt_nxt.busy = 1'b1;
         end
         if (stuck)
            mt_nxt.duty = cmd ? `DUTY_FULL : 8'h00;
         mt_nxt.tot = 14'h0001;
         mt_nxt.hi = {13'h0000, cmd};
      end else begin
         mt_nxt.tot = mt_r.tot + 14'h0001;
         mt_nxt.hi = mt_r.hi + {13'h0000, cmd};
      end
      if (mt_r.busy) begin
         if (rem2 >= {1'b0, mt_r.den}) begin
            mt_nxt.rem = rem2 - {1'b0, mt_r.den};
            mt_nxt.quo = {mt_r.quo[6:0], 1'b1};
         end else begin
            mt_nxt.rem = rem2;
            mt_nxt.quo = {mt_r.quo[6:0], 1'b0};
         end
         mt_nxt.bits = mt_r.bits - 4'h1;
         if (mt_r.bits == 4'h1) begin
            mt_nxt.duty = mt_nxt.quo;
            mt_nxt.busy = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         mt_r <= '0;
      else
         mt_r <= mt_nxt;
   end

   assign duty = mt_r.duty;
endmodule : duty_meter

/* fan_partner.sv */
// speed command source and hall switch model
`timescale 1ns/1ps
module fan_partner (
   input  wire logic        clk,
   input  wire logic [15:0] cmd_period,
   input  wire logic [15:0] cmd_high,
   input  wire logic [15:0] hall_half,
   output logic             speed_cmd,
   output logic             hall_input,
   output logic [15:0]      hall_flips
);
   logic [15:0] pc, hc, per, hi;
   initial begin
      pc = 16'h0000;
      hc = 16'h0000;
      per = 16'h06A4;
      hi = 16'h0000;
      hall_input = 1'b0;
      hall_flips = 16'h0000;
   end
   // ******************************
   // command pwm and hall rotation
   // ******************************
   always @(posedge clk) begin
      if (pc + 16'h0001 >= per) begin
         pc <= 16'h0000;
         per <= cmd_period;
         hi <= cmd_high;
      end else begin
         pc <= pc + 16'h0001;
      end
      if (hall_half != 16'h0000 && hc + 16'h0001 >= hall_half) begin
         hc <= 16'h0000;
         hall_input <= ~hall_input;
         hall_flips <= hall_flips + 16'h0001;
      end else if (hall_half != 16'h0000) begin
         hc <= hc + 16'h0001;
      end
   end
   assign speed_cmd = (pc < hi);
endmodule : fan_partner

/* tb_fan_commutator.sv */
// self-checking bench for the fan commutator
`timescale 1ns/1ps
`include "fan_map.svh"
module tb_fan_commutator import fan_pkg::*;;
   localparam int LOCK_ON  = 14000;
   localparam int LOCK_OFF = 2000;
   typedef struct packed {
      logic [1:0]  lvl;
      logic [7:0]  ext;
      logic [15:0] high;
      logic [1:0]  exp;
   } row_t;
   logic        clk, sys_rst, cap, oc, cz, spd, hall;
   logic [1:0]  min_lvl;
   logic [7:0]  ext_min, duty2;
   logic [15:0] cmd_high, hall_half, flips;
   logic        out_a, oe_a_n, out_b, oe_b_n, min_act, shut, lock;
   int          fails, n_compared, cyc, t1, t2, ca, cb;
   // min flag, shutdown flag per row
   row_t rows [7] = '{
      '{2'h2, 8'h00, 16'h0352, 2'b00},
      '{2'h2, 8'h00, 16'h0055, 2'b10},
      '{2'h3, 8'h00, 16'h0055, 2'b10},
      '{2'h1, 8'h80, 16'h01A9, 2'b10},
      '{2'h1, 8'h10, 16'h01A9, 2'b00},
      '{2'h0, 8'h00, 16'h0352, 2'b00},
      '{2'h0, 8'h00, 16'h0055, 2'b01}};
   fan_partner u_far (
      .clk        (clk),
      .cmd_period (16'h06A4),
      .cmd_high   (cmd_high),
      .hall_half  (hall_half),
      .speed_cmd  (spd),
      .hall_input (hall),
      .hall_flips (flips)
   );
   fan_commutator #(
      .LOCK_ON_CYC  (LOCK_ON),
      .LOCK_OFF_CYC (LOCK_OFF),
      .SS_STEP_CYC  (8)
   ) u_dut (
      .clk                 (clk),
      .sys_rst             (sys_rst),
      .speed_cmd           (spd),
      .hall_input          (hall),
      .min_speed_level     (min_lvl),
      .ext_min_duty        (ext_min),
      .restart_current_cap (cap),
      .overcurrent         (oc),
      .current_zero        (cz),
      .bridge_out_a        (out_a),
      .bridge_out_a_oe_n   (oe_a_n),
      .bridge_out_b        (out_b),
      .bridge_out_b_oe_n   (oe_b_n),
      .min_speed_active    (min_act),
      .shutdown_active     (shut),
      .lock_active         (lock),
      .duty_at_second_edge (duty2)
   );
   // ******************************
   // clock, timeout and tasks
   // ******************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
   end
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic wait_flips(input int n);
      logic [15:0] tgt;
      tgt = flips + 16'(n);
      for (int i = 0; i < 4000 * n && flips !== tgt; i++) tick(1);
   endtask : wait_flips
   task automatic count_hi(input int n, output int a, output int b);
      a = 0;
      b = 0;
      repeat (n) begin
         tick(1);
         a += int'(out_a === 1'b1);
         b += int'(out_b === 1'b1);
      end
   endtask : count_hi
   task automatic next_rise(output int t);
      logic pv;
      pv = 1'b1;
      for (int i = 0; i < 5000; i++) begin
         tick(1);
         if (!pv && (out_a | out_b) === 1'b1) break;
         pv = out_a | out_b;
      end
      t = cyc;
   endtask : next_rise
   task automatic wait_lock(input logic v, output int t);
      for (int i = 0; i < 20000 && lock !== v; i++) tick(1);
      t = cyc;
   endtask : wait_lock
   // ******************************
   // main sequence
   // ******************************
   initial begin
      sys_rst = 1'b1;
      cap = 1'b0;
      oc = 1'b0;
      cz = 1'b1;
      min_lvl = 2'h2;
      ext_min = 8'h00;
      cmd_high = 16'h0352;
      hall_half = 16'h0000;
      fails = 0;
      n_compared = 0;
      fork
      begin
      tick(8);
      cmp({out_a, out_b, lock, duty2}, 0);
      sys_rst <= 1'b0;
      tick(2500);
      next_rise(t1);
      next_rise(t2);
      cmp(t2 - t1, `PWM_PERIOD);
      hall_half <= 16'd2000;
      wait_flips(2);
      tick(10);
      cmp(duty2, 8'hFF);
      $display("test output rate done");
      cap <= 1'b1;
      sys_rst <= 1'b1;
      tick(2);
      cmp({out_a, out_b, lock, duty2}, 0);
      sys_rst <= 1'b0;
      count_hi(2500, ca, cb);
      cmp(ca + cb, 0);
      wait_flips(2);
      tick(10);
      cmp(duty2, 8'h00);
      cap <= 1'b0;
      wait_flips(2);
      $display("test start limit done");
      cmd_high <= 16'h069A;
      cz <= 1'b0;
      wait_flips(1);
      repeat (2) begin
         tick(200);
         count_hi(1600, ca, cb);
         cmp({ca > 0, cb > 0}, hall ? 2'b10 : 2'b01);
         wait_flips(1);
      end
      tick(1995);
      cmp(oe_a_n ^ oe_b_n, 1'b1);
      cz <= 1'b1;
      wait_flips(4);
      tick(1995);
      cmp(oe_a_n | oe_b_n, 1'b0);
      $display("test off gap done");
      foreach (rows[i]) begin
         min_lvl <= rows[i].lvl;
         ext_min <= rows[i].ext;
         cmd_high <= rows[i].high;
         tick(3500);
         cmp({min_act, shut}, rows[i].exp);
      end
      $display("test minimum speed done");
      min_lvl <= 2'h2;
      cmd_high <= 16'h069A;
      tick(500);
      oc <= 1'b1;
      tick(100);
      oc <= 1'b0;
      count_hi(3846, ca, cb);
      cmp(ca + cb > 0, 1'b1);
      oc <= 1'b1;
      tick(200);
      oc <= 1'b0;
      count_hi(1500, ca, cb);
      cmp(ca + cb, 0);
      cmp(lock, 1'b0);
      tick(LOCK_OFF);
      $display("test overcurrent done");
      wait_flips(1);
      hall_half <= 16'h0000;
      t1 = cyc;
      wait_lock(1'b1, t2);
      cmp(t2 - t1 >= LOCK_ON - 10 && t2 - t1 <= LOCK_ON + 10, 1);
      count_hi(1000, ca, cb);
      cmp(ca + cb, 0);
      wait_lock(1'b0, t1);
      cmp(t1 - t2 >= LOCK_OFF - 10 && t1 - t2 <= LOCK_OFF + 10, 1);
      $display("test lock done");
      end
      begin
         wait (cyc >= 98000);
         fails++;
      end
      join_any
      stop_test();
   end
endmodule : tb_fan_commutator
